// >>> core/pwr_key_pkg.sv
// Constants and types shared by the power key and reset request logic
// Contract
// R1 - Every control input is debounced; all filters share one programmable debounce time.
// R2 - Detect press and release of the power key and measure time between.
// R3 - Key edge detection stays active in every power mode, including low-power off.
// R4 - Debounced power key level is readable as a status bit.
// R5 - Power key mask suppresses both interrupt and wakeup from key events.
// R6 - Four key behaviours chosen by a two-bit function select.
// R7 - Select 00: event on press; unmasked it interrupts and wakes from off state.
// R8 - Select 01: short press event at release; long press event plus lock.
// R9 - Select 10: like 01, long press also clears run request (power-down).
// R10 - Select 11: short clears run, sets standby; long sets lock, clears both.
// R11 - With lock set, only a press longer than the delay wakes the device.
// R12 - Host must clear the lock before off state for short-press wakeup.
// R13 - Asserting the active-low reset request sends the sequencer to reset state.
// R14 - Fast-shutdown select shortens the sequencer transition into reset state.
// R15 - Before reset state, set the fault-log bit and assert host reset output.
// R16 - Host reset output is active low and resets the host processor.
// R17 - Interrupt asserts on unmasked events and stays until all events cleared.
// R18 - Press timer runs from debounced level, restarts on press, stops on release.
package pwr_key_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DEBOUNCE = 8'h04;
  localparam logic [7:0] ADDR_KEY_DELAY = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_EVENT = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  localparam logic [7:0] ADDR_FAULT = 8'h18;

  // CTRL fields
  localparam int CTRL_FSEL_LSB = 0;
  localparam int CTRL_FAST = 2;
  localparam int CTRL_SYSEN = 3;
  localparam int CTRL_STANDBY = 4;
  localparam int CTRL_LOCK = 5;

  // STATUS, EVENT and MASK bit positions
  localparam int BIT_KEY = 0;
  localparam int BIT_RSTREQ = 1;
  localparam int STAT_TIMING = 2;

  // Reset values
  localparam logic [1:0] FSEL_RST = 2'h0;
  localparam logic [7:0] DEBOUNCE_RST = 8'h0a;
  localparam logic [7:0] KEY_DELAY_RST = 8'h64;
  localparam logic SYSEN_RST = 1'b1;

  // Function select codes
  localparam logic [1:0] FSEL_PRESS = 2'h0;
  localparam logic [1:0] FSEL_LOCK = 2'h1;
  localparam logic [1:0] FSEL_LOW_POWER_OFF_STATE = 2'h2;
  localparam logic [1:0] FSEL_STANDBY = 2'h3;

  // Timebase: debounce and press timers count 1 ms ticks
  localparam int CLK_MHZ = 100;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES = TICK_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avs_req_t;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } avs_rsp_t;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] level;
    logic [1:0][7:0] dcnt;
    logic [16:0] presc;
    logic tick;
    logic [7:0] ptime;
    logic running;
    logic long_done;
    logic [1:0] fsel;
    logic fast_sel;
    logic system_en;
    logic standby;
    logic lock;
    logic [7:0] dbt;
    logic [7:0] key_delay;
    logic [1:0] evt;
    logic [1:0] mask;
    logic fault;
    logic irq_n;
    logic host_rst_n;
    logic reset_entry;
    logic fast_out;
    logic wakeup;
    avs_rsp_t rsp;
  } key_state_t;

endpackage

// >>> core/pwr_key_ctrl.sv
// Power key and host reset request input handling with Avalon-MM registers
`timescale 1ns/10ps
module pwr_key_ctrl #(
  parameter int TICK_COUNT = pwr_key_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register bus
  input wire pwr_key_pkg::avs_req_t avs_req,
  output pwr_key_pkg::avs_rsp_t avs_rsp,
  // Pins
  input wire logic power_key_input_n,
  input wire logic host_reset_request_input_n,
  output logic host_reset_output_n,
  output logic interrupt_request_output_n,
  // Power sequencer
  input wire logic low_power_off_state,
  input wire logic seq_reset_done,
  output logic reset_state_request,
  output logic fast_shutdown_select,
  output logic system_run_request,
  output logic standby_flag,
  output logic long_press_lock_flag,
  output logic wakeup_pulse
);
  import pwr_key_pkg::*;

  localparam logic [16:0] TICK_LAST = 17'(TICK_COUNT - 1);

  key_state_t q, d;
  logic press, release_k, short_ev, long_ev, rr_assert, key_ev, wake_ok;
  logic acc, wr_en;
  logic [7:0] wbyte;

  function automatic logic [31:0] read_mux(input key_state_t s, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0;
    unique case (a)
      ADDR_CTRL: begin
        r[CTRL_FSEL_LSB +: 2] = s.fsel;
        r[CTRL_FAST] = s.fast_sel;
        r[CTRL_SYSEN] = s.system_en;
        r[CTRL_STANDBY] = s.standby;
        r[CTRL_LOCK] = s.lock;
      end
      ADDR_DEBOUNCE: r[7:0] = s.dbt;
      ADDR_KEY_DELAY: r[7:0] = s.key_delay;
      ADDR_STATUS: begin
        r[BIT_KEY] = s.level[BIT_KEY]; // R4
        r[BIT_RSTREQ] = s.level[BIT_RSTREQ];
        r[STAT_TIMING] = s.running;
      end
      ADDR_EVENT: r[1:0] = s.evt;
      ADDR_MASK: r[1:0] = s.mask;
      ADDR_FAULT: r[0] = s.fault;
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  always_comb begin
    d = q;
    // Synchronisers: sync1 feeds only sync2
    d.sync1 = {host_reset_request_input_n, power_key_input_n};
    d.sync2 = q.sync1;
    // Shared 1 ms timebase
    d.tick = 1'b0;
    if (q.presc == TICK_LAST) begin
      d.presc = 17'h0;
      d.tick = 1'b1;
    end else begin
      d.presc = q.presc + 17'h1;
    end
    // Both inputs use the single debounce setting; a glitch restarts the count
    for (int i = 0; i < 2; i++) begin
      if (q.sync2[i] == q.level[i]) begin
        d.dcnt[i] = 8'h0; // R1
      end else if (q.dcnt[i] >= q.dbt) begin
        d.level[i] = q.sync2[i]; // R1
        d.dcnt[i] = 8'h0;
      end else if (q.tick) begin
        d.dcnt[i] = q.dcnt[i] + 8'h1;
      end
    end
    // Edge detection runs regardless of the power mode
    press = q.level[BIT_KEY] && !d.level[BIT_KEY]; // R2 R3
    release_k = !q.level[BIT_KEY] && d.level[BIT_KEY]; // R2
    rr_assert = q.level[BIT_RSTREQ] && !d.level[BIT_RSTREQ]; // R13
    long_ev = q.running && !q.long_done && q.ptime >= q.key_delay;
    // A release in the cycle after the tick that completes the delay counts as a long press only
    short_ev = release_k && q.running && !q.long_done && !long_ev;
    // Press timer
    if (press) begin
      d.ptime = 8'h0; // R18
      d.running = 1'b1;
      d.long_done = 1'b0;
    end else if (release_k) begin
      d.running = 1'b0; // R18
    end else if (q.running && q.tick && q.ptime != 8'hff) begin
      d.ptime = q.ptime + 8'h1;
    end
    if (long_ev) begin
      d.long_done = 1'b1;
    end
    // Bus: request seen -> answer next cycle -> write lands on the answered edge
    acc = (avs_req.read || avs_req.write) && !q.rsp.waitrequest;
    wr_en = acc && avs_req.write && avs_req.byteenable[0];
    wbyte = avs_req.writedata[7:0];
    d.rsp.waitrequest = !((avs_req.read || avs_req.write) && q.rsp.waitrequest);
    d.rsp.readdata = read_mux(q, avs_req.address);
    if (wr_en) begin
      unique case (avs_req.address)
        ADDR_CTRL: begin
          d.fsel = wbyte[CTRL_FSEL_LSB +: 2];
          d.fast_sel = wbyte[CTRL_FAST];
          d.system_en = wbyte[CTRL_SYSEN];
          d.standby = wbyte[CTRL_STANDBY];
          d.lock = wbyte[CTRL_LOCK];
        end
        ADDR_DEBOUNCE: d.dbt = wbyte;
        ADDR_KEY_DELAY: d.key_delay = wbyte;
        ADDR_EVENT: d.evt = q.evt & ~wbyte[1:0];
        ADDR_MASK: d.mask = wbyte[1:0];
        ADDR_FAULT: d.fault = q.fault & ~wbyte[0];
        default: d.fault = d.fault;
      endcase
    end
    // Key behaviour per function select; hardware updates win over a same-cycle write
    key_ev = 1'b0;
    wake_ok = 1'b0;
    unique case (q.fsel) // R6
      FSEL_PRESS: begin
        key_ev = press; // R7
        wake_ok = (press && !q.lock) || (long_ev && q.lock); // R7 R11
      end
      default: begin
        key_ev = short_ev || long_ev; // R8
        wake_ok = (short_ev && !q.lock) || long_ev; // R11
      end
    endcase
    if (q.fsel != FSEL_PRESS && long_ev) begin
      d.lock = 1'b1; // R8
    end
    if (q.fsel == FSEL_PRESS && long_ev) begin
      d.lock = 1'b1;
    end
    if (q.fsel == FSEL_LOW_POWER_OFF_STATE && long_ev) begin
      d.system_en = 1'b0; // R9
    end
    if (q.fsel == FSEL_STANDBY && short_ev) begin
      d.system_en = 1'b0; // R10
      d.standby = 1'b1;
    end
    if (q.fsel == FSEL_STANDBY && long_ev) begin
      d.system_en = 1'b0; // R10
      d.standby = 1'b0;
    end
    if (key_ev) begin
      d.evt[BIT_KEY] = 1'b1;
    end
    // Mask blocks the wake as well as the interrupt
    d.wakeup = wake_ok && low_power_off_state && !q.mask[BIT_KEY]; // R5 R7
    // Reset request: log and hold host in reset first, then ask the sequencer
    if (rr_assert) begin
      d.fault = 1'b1; // R15
      d.evt[BIT_RSTREQ] = 1'b1;
      d.host_rst_n = 1'b0; // R15 R16
    end
    if (!q.host_rst_n && !q.reset_entry) begin
      d.reset_entry = 1'b1; // R13
    end
    if (seq_reset_done) begin
      d.reset_entry = 1'b0;
      d.host_rst_n = 1'b1;
    end
    d.fast_out = q.fast_sel; // R14
    d.irq_n = !(|(q.evt & ~q.mask)); // R5 R17
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.sync1 <= 2'h3;
      q.sync2 <= 2'h3;
      q.level <= 2'h3;
      q.fsel <= FSEL_RST;
      q.system_en <= SYSEN_RST;
      q.dbt <= DEBOUNCE_RST;
      q.key_delay <= KEY_DELAY_RST;
      q.irq_n <= 1'b1;
      q.host_rst_n <= 1'b1;
      q.rsp.waitrequest <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign avs_rsp = q.rsp;
  assign host_reset_output_n = q.host_rst_n;
  assign interrupt_request_output_n = q.irq_n;
  assign reset_state_request = q.reset_entry;
  assign fast_shutdown_select = q.fast_out;
  assign system_run_request = q.system_en;
  assign standby_flag = q.standby;
  assign long_press_lock_flag = q.lock;
  assign wakeup_pulse = q.wakeup;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence key_pressed;
    $fell(q.level[BIT_KEY]);
  endsequence

  sequence rr_seen;
    $fell(q.level[BIT_RSTREQ]);
  endsequence

  AST_DEBOUNCE_STABLE: assert property ( // R1
    $changed(q.level) |-> $past(q.sync2) != $past(q.level))
    else $error("Debounced level moved without a differing synchronised input");

  AST_TIMER_RESTART: assert property ( // R18
    key_pressed |-> q.running && q.ptime == 8'h0 && !q.long_done)
    else $error("Press timer did not restart on key press");

  AST_TIMER_STOP: assert property ( // R2
    $rose(q.level[BIT_KEY]) |-> !q.running)
    else $error("Press timer still running after release");

  AST_STATUS_READ: assert property ( // R4
    (avs_req.read && q.rsp.waitrequest && avs_req.address == ADDR_STATUS)
      |=> avs_rsp.readdata[BIT_KEY] == $past(q.level[BIT_KEY]))
    else $error("Status read does not show debounced key level");

  AST_MASK_NO_WAKE: assert property ( // R5
    $past(q.mask[BIT_KEY]) |-> !q.wakeup)
    else $error("Wakeup raised while key masked");

  AST_PRESS_WAKE: assert property ( // R7
    (q.fsel == FSEL_PRESS && !q.lock && !q.mask[BIT_KEY] && low_power_off_state
      && q.level[BIT_KEY] && !d.level[BIT_KEY]) |=> q.wakeup && q.evt[BIT_KEY])
    else $error("Mode 00 press did not wake and raise event");

  AST_LONG_LOCK: assert property ( // R8
    (q.fsel == FSEL_LOCK && q.running && !q.long_done && q.ptime >= q.key_delay)
      |=> q.lock && q.evt[BIT_KEY])
    else $error("Long press did not set lock and event");

  AST_STANDBY_SHORT: assert property ( // R10
    (q.fsel == FSEL_STANDBY && q.running && !q.long_done && q.ptime < q.key_delay
      && !q.level[BIT_KEY] && d.level[BIT_KEY]) |=> !q.system_en && q.standby)
    else $error("Short press in mode 11 did not enter standby");

  AST_RESET_SEQ: assert property ( // R15
    rr_seen ##0 (!seq_reset_done && !q.reset_entry)
      |=> (!q.host_rst_n && q.fault) ##1 (q.reset_entry || $past(seq_reset_done)))
    else $error("Reset request not logged and host reset before reset entry");

  AST_IRQ_LEVEL: assert property ( // R17
    |(q.evt & ~q.mask) |=> !q.irq_n)
    else $error("Interrupt not asserted for pending unmasked event");

endmodule

// >>> tb/seq_partner.sv
// Sequencer model facing the power key block
`timescale 1ns/10ps
module seq_partner #(
  parameter int LAT = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Device side
  input wire logic reset_state_request,
  input wire logic system_run_request,
  input wire logic wakeup_pulse,
  output logic seq_reset_done,
  output logic low_power_off_state
);
  int cnt_q;
  logic run_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q <= 0;
      run_q <= 1'b1;
      low_power_off_state <= 1'b0;
      seq_reset_done <= 1'b0;
    end else begin
      run_q <= system_run_request;
      cnt_q <= reset_state_request ? cnt_q + 1 : 0;
      // One pulse only, so a stuck request is not released twice
      seq_reset_done <= reset_state_request && (cnt_q == LAT);
      if (wakeup_pulse) begin
        low_power_off_state <= 1'b0;
      end else if (run_q && !system_run_request) begin
        low_power_off_state <= 1'b1;
      end
    end
  end
endmodule

// >>> tb/tb_top.sv
// Bench for the power key and host reset request block
`timescale 1ns/10ps
module tb_top;
  import pwr_key_pkg::*;
  logic ref_clk, rst_n, key_n, rreq_n;
  avs_req_t req;
  avs_rsp_t rsp;
  logic hrst_n, irq_n, rs_req, fast, run, stby, lock, wake, done, off;
  int fails = 0;
  int total_checks = 0;
  int wakes = 0;
  int cyc = 0;
  int n, w0;
  logic [31:0] q;
  pwr_key_ctrl #(.TICK_COUNT(4)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .avs_req(req),
    .avs_rsp(rsp), .power_key_input_n(key_n), .host_reset_request_input_n(rreq_n),
    .host_reset_output_n(hrst_n), .interrupt_request_output_n(irq_n),
    .low_power_off_state(off), .seq_reset_done(done), .reset_state_request(rs_req),
    .fast_shutdown_select(fast), .system_run_request(run), .standby_flag(stby),
    .long_press_lock_flag(lock), .wakeup_pulse(wake));
  seq_partner part_u (.ref_clk(ref_clk), .rst_n(rst_n), .reset_state_request(rs_req),
    .system_run_request(run), .wakeup_pulse(wake), .seq_reset_done(done),
    .low_power_off_state(off));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (wake === 1'b1) wakes <= wakes + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Read right after a rising edge: the design has not yet updated, so this is what it sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    req.read <= ~w;
    req.write <= w;
    req.address <= a;
    req.writedata <= d;
    do begin
      @(posedge ref_clk);
      k++;
    end while (rsp.waitrequest !== 1'b0 && k < 20);
    chk("waitrequest", 32'h0, 32'(rsp.waitrequest));
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q & m);
  endtask
  task automatic press(input int len);
    @(posedge ref_clk);
    key_n <= 1'b0;
    repeat (len) @(posedge ref_clk);
    key_n <= 1'b1;
    repeat (40) @(negedge ref_clk);
  endtask
  initial begin
    rst_n = 1'b0;
    key_n = 1'b1;
    rreq_n = 1'b1;
    req = '0;
    req.byteenable = 4'h1;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(ADDR_CTRL, 32'hff, 32'h08);
    rd(ADDR_DEBOUNCE, 32'hffffffff, 32'h0a);
    rd(ADDR_KEY_DELAY, 32'hff, 32'h64);
    rd(8'h1c, 32'hffffffff, 32'h0);
    rd(ADDR_STATUS, 32'h1, 32'h1);
    wr(ADDR_DEBOUNCE, 32'h2);
    wr(ADDR_KEY_DELAY, 32'ha);
    key_n <= 1'b0;
    repeat (20) @(negedge ref_clk);
    rd(ADDR_STATUS, 32'h1, 32'h0);
    rd(ADDR_EVENT, 32'h1, 32'h1);
    chk("irq", 32'h0, 32'(irq_n));
    press(1);
    wr(ADDR_EVENT, 32'h1);
    repeat (3) @(negedge ref_clk);
    chk("irq", 32'h1, 32'(irq_n));
    wr(ADDR_CTRL, 32'h09);
    press(16);
    rd(ADDR_EVENT, 32'h1, 32'h1);
    chk("lock", 32'h0, 32'(lock));
    wr(ADDR_EVENT, 32'h1);
    press(80);
    chk("lock", 32'h1, 32'(lock));
    wr(ADDR_CTRL, 32'h0a);
    press(80);
    chk("run", 32'h0, 32'(run));
    chk("off", 32'h1, 32'(off));
    wr(ADDR_EVENT, 32'h1);
    w0 = wakes;
    press(16);
    chk("wakes", 32'(w0), 32'(wakes));
    press(80);
    chk("wakes", 32'(w0 + 1), 32'(wakes));
    wr(ADDR_CTRL, 32'h0a);
    wr(ADDR_CTRL, 32'h02);
    wr(ADDR_EVENT, 32'h1);
    wr(ADDR_MASK, 32'h1);
    press(16);
    chk("irq", 32'h1, 32'(irq_n));
    chk("wakes", 32'(w0 + 1), 32'(wakes));
    rd(ADDR_EVENT, 32'h1, 32'h1);
    wr(ADDR_MASK, 32'h0);
    wr(ADDR_EVENT, 32'h1);
    press(16);
    chk("wakes", 32'(w0 + 2), 32'(wakes));
    wr(ADDR_CTRL, 32'h0b);
    press(16);
    chk("run", 32'h0, 32'(run));
    chk("standby", 32'h1, 32'(stby));
    wr(ADDR_CTRL, 32'h1b);
    press(80);
    chk("standby", 32'h0, 32'(stby));
    chk("run", 32'h0, 32'(run));
    chk("lock", 32'h1, 32'(lock));
    wr(ADDR_EVENT, 32'h3);
    wr(ADDR_CTRL, 32'h08);
    wr(ADDR_CTRL, 32'h00);
    repeat (3) @(negedge ref_clk);
    chk("off", 32'h1, 32'(off));
    w0 = wakes;
    press(16);
    chk("wakes", 32'(w0 + 1), 32'(wakes));
    wr(ADDR_EVENT, 32'h1);
    wr(ADDR_CTRL, 32'h0c);
    repeat (2) @(negedge ref_clk);
    chk("fast", 32'h1, 32'(fast));
    @(posedge ref_clk);
    rreq_n <= 1'b0;
    n = 0;
    while (rs_req !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    chk("reset_state_request", 32'h1, 32'(rs_req));
    chk("host_reset", 32'h0, 32'(hrst_n));
    @(posedge ref_clk);
    rreq_n <= 1'b1;
    repeat (40) @(negedge ref_clk);
    chk("host_reset", 32'h1, 32'(hrst_n));
    rd(ADDR_FAULT, 32'h1, 32'h1);
    rd(ADDR_EVENT, 32'h2, 32'h2);
    give_verdict();
  end
endmodule
